// ### tsa_defs.vh
`ifndef TSA_DEFS_VH
`define TSA_DEFS_VH
// ----------------------------------------------------------------------
// How it works
// - din sampled on rising sclk, dout changes on falling sclk.
// - command bit 6 high reads, low writes.
// - command bits 5..3 pick the register; commands may follow back to back in one frame.
// - write command is followed by 8 or 16 data bits, then loaded.
// - read returns 8 or 16 bits msb first, msb driven before the first falling edge.
// - chip select works as frame sync; sclk may run between frames.
// - chip select tied low still works as a 3-wire port.
// - 32 consecutive ones sampled on din reset the serial port.
// - port reset restarts command capture and restores all registers.
// - limit alarm has comparator and interrupt modes; interrupt at power-up.
// - limit alarm fires above high limit or below low limit.
// - comparator mode releases alarm only past the hysteresis band.
// - comparator mode keeps the limit alarm through shutdown.
// - interrupt mode releases the limit alarm on any register read.
// - interrupt mode re-fires only on a fresh out-of-limit event.
// - interrupt mode clears the limit alarm on entering shutdown.
// - critical alarm fires when temperature exceeds critical limit.
// - hysteresis is 4 bits of whole degrees, off high/crit, onto low.
// - in 13-bit mode low temperature bits show low, high, crit flags.
// ----------------------------------------------------------------------
`define TSA_ADDR_STATUS 3'h0
`define TSA_ADDR_CFG 3'h1
`define TSA_ADDR_TEMP 3'h2
`define TSA_ADDR_ID 3'h3
`define TSA_ADDR_CRIT 3'h4
`define TSA_ADDR_HYST 3'h5
`define TSA_ADDR_HIGH 3'h6
`define TSA_ADDR_LOW 3'h7
`define TSA_CMD_RD_BIT 6
`define TSA_CMD_ADDR_HI 5
`define TSA_CMD_ADDR_LO 3
`define TSA_CFG_RES_BIT 7
`define TSA_CFG_OPM_HI 6
`define TSA_CFG_OPM_LO 5
`define TSA_CFG_CMP_BIT 4
`define TSA_CFG_INTPOL_BIT 3
`define TSA_CFG_CTPOL_BIT 2
`define TSA_OPM_SHUTDOWN 2'h3
`define TSA_CFG_RST 8'h00
`define TSA_CRIT_RST 16'h4980
`define TSA_HYST_RST 8'h05
`define TSA_HIGH_RST 16'h2000
`define TSA_LOW_RST 16'h0500
`define TSA_CMD_LAST 5'h07
`define TSA_NARROW_LAST 5'h07
`define TSA_WIDE_LAST 5'h0F
`define TSA_ONES_LAST 5'h1F
`define TSA_HYST_SHIFT 7
// 500 us of quiet after a port reset, counted at 200 MHz
`define TSA_RESYNC_CYC 17'h186A0
`endif

// ### tsa_alarm.v
`include "tsa_defs.vh"

module tsa_alarm (
  // system
  input wire clk_sys,
  input wire rst_n,
  input wire clear,
  // measurement and limits
  input wire [15:0] temp_value,
  input wire [15:0] high_limit,
  input wire [15:0] low_limit,
  input wire [15:0] critical_limit,
  input wire [3:0] hysteresis_value,
  // control
  input wire cmp_mode,
  input wire shutdown,
  input wire int_pol_high,
  input wire ct_pol_high,
  input wire rd_stb,
  // results
  output reg int_oe_q,
  output reg ct_oe_q,
  output reg [2:0] flag_q
);

  // ----------------------------------------------------------------
  // limit comparisons
  // ----------------------------------------------------------------
  wire signed [16:0] t_s = {temp_value[15], temp_value};
  wire signed [16:0] hi_s = {high_limit[15], high_limit};
  wire signed [16:0] lo_s = {low_limit[15], low_limit};
  wire signed [16:0] cr_s = {critical_limit[15], critical_limit};
  wire signed [16:0] hys_s = {6'h00, hysteresis_value, 7'h00};
  wire signed [16:0] hi_rel = hi_s - hys_s;
  wire signed [16:0] lo_rel = lo_s + hys_s;
  wire signed [16:0] cr_rel = cr_s - hys_s;
  wire over = t_s > hi_s;
  wire under = t_s < lo_s;
  wire crit_ev = t_s > cr_s;

  reg hi_act_q;
  reg lo_act_q;
  reg cr_act_q;
  reg lim_prev_q;
  reg int_act_q;
  wire lim_act = hi_act_q | lo_act_q;
  wire lim_set = lim_act & ~lim_prev_q & ~shutdown;

  // ----------------------------------------------------------------
  // alarm state
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n || clear) begin
      hi_act_q <= 1'b0;
      lo_act_q <= 1'b0;
      cr_act_q <= 1'b0;
      lim_prev_q <= 1'b0;
      int_act_q <= 1'b0;
      int_oe_q <= 1'b0;
      ct_oe_q <= 1'b0;
      flag_q <= 3'h0;
    end else begin
      flag_q <= {crit_ev, over, under};
      // frozen in shutdown, so comparator state holds
      if (!shutdown) begin
        if (over)
          hi_act_q <= 1'b1;
        else if (t_s < hi_rel)
          hi_act_q <= 1'b0;
        if (under)
          lo_act_q <= 1'b1;
        else if (t_s > lo_rel)
          lo_act_q <= 1'b0;
        if (crit_ev)
          cr_act_q <= 1'b1;
        else if (t_s < cr_rel)
          cr_act_q <= 1'b0;
      end
      lim_prev_q <= lim_act;
      if (cmp_mode) begin
        int_act_q <= lim_act;
      end else if (lim_set) begin
        // a fresh event wins over a read in the same cycle
        int_act_q <= 1'b1;
      end else if (rd_stb) begin
        int_act_q <= 1'b0;
      end else if (shutdown) begin
        int_act_q <= 1'b0;
      end
      int_oe_q <= int_act_q ^ int_pol_high;
      ct_oe_q <= cr_act_q ^ ct_pol_high;
    end
  end

endmodule

// ### tsa_sensor.v
`include "tsa_defs.vh"

module tsa_sensor #(
  // arbitrary neutral identity value
  parameter [7:0] ID_CODE = 8'h5A,
  parameter [16:0] RESYNC_CYCLES = `TSA_RESYNC_CYC
) (
  // system
  input wire clk_sys,
  input wire rst_n,
  // serial pins
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_din,
  output wire spi_dout,
  output wire spi_dout_oe,
  // measured temperature from the converter
  input wire [15:0] temp_value,
  // open-drain alarm pins, high pulls the pin low
  output wire limit_alarm_oe,
  output wire critical_alarm_out_oe,
  // state toward the converter
  output wire shutdown,
  output wire resolution_16,
  output wire sif_recovering
);

  // ----------------------------------------------------------------
  // pin synchronisers: sclk, cs_n, din
  // ----------------------------------------------------------------
  localparam [2:0] PIN_IDLE = 3'h3;
  wire [2:0] pin_raw = {spi_din, spi_cs_n, spi_sclk};
  wire [2:0] pin_f;
  reg [2:0] pin_prev_q;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg f_q;
      always @(posedge clk_sys) begin
        if (!rst_n) begin
          s1_q <= PIN_IDLE[gi];
          s2_q <= PIN_IDLE[gi];
          s3_q <= PIN_IDLE[gi];
          f_q <= PIN_IDLE[gi];
        end else begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q)
            f_q <= s3_q;
        end
      end
      assign pin_f[gi] = f_q;
    end
  endgenerate

  always @(posedge clk_sys) begin
    if (!rst_n)
      pin_prev_q <= PIN_IDLE;
    else
      pin_prev_q <= pin_f;
  end

  wire sclk_rise = pin_f[0] & ~pin_prev_q[0];
  wire sclk_fall = ~pin_f[0] & pin_prev_q[0];
  wire cs_low = ~pin_f[1];
  wire cs_fall = ~pin_f[1] & pin_prev_q[1];
  wire cs_rise = pin_f[1] & ~pin_prev_q[1];
  wire din_f = pin_f[2];

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  reg [7:0] cfg_q;
  reg [15:0] crit_q;
  reg [7:0] hyst_q;
  reg [15:0] high_q;
  reg [15:0] low_q;
  wire [2:0] flags;
  reg wr_stb_q;
  reg [15:0] wr_data_q;
  reg [2:0] addr_q;
  reg sif_rst_q;

  always @(posedge clk_sys) begin
    if (!rst_n || sif_rst_q) begin
      cfg_q <= `TSA_CFG_RST;
      crit_q <= `TSA_CRIT_RST;
      hyst_q <= `TSA_HYST_RST;
      high_q <= `TSA_HIGH_RST;
      low_q <= `TSA_LOW_RST;
    end else if (wr_stb_q) begin
      case (addr_q)
        `TSA_ADDR_CFG: cfg_q <= wr_data_q[7:0];
        `TSA_ADDR_CRIT: crit_q <= wr_data_q;
        `TSA_ADDR_HYST: hyst_q <= wr_data_q[7:0];
        `TSA_ADDR_HIGH: high_q <= wr_data_q;
        `TSA_ADDR_LOW: low_q <= wr_data_q;
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  wire res16 = cfg_q[`TSA_CFG_RES_BIT];
  wire sd_mode = (cfg_q[`TSA_CFG_OPM_HI:`TSA_CFG_OPM_LO] ==
                  `TSA_OPM_SHUTDOWN);

  // ----------------------------------------------------------------
  // command decode and read data
  // ----------------------------------------------------------------
  reg [15:0] in_sr_q;
  wire [7:0] cmd_byte = {in_sr_q[6:0], din_f};
  wire [2:0] cmd_addr = cmd_byte[`TSA_CMD_ADDR_HI:`TSA_CMD_ADDR_LO];
  wire cmd_rd = cmd_byte[`TSA_CMD_RD_BIT];
  wire cmd_wide = (cmd_addr == `TSA_ADDR_TEMP) ||
                  (cmd_addr == `TSA_ADDR_CRIT) ||
                  (cmd_addr == `TSA_ADDR_HIGH) ||
                  (cmd_addr == `TSA_ADDR_LOW);
  reg [15:0] rd_word;

  // read data left aligned so the msb always leaves first
  always @* begin
    rd_word = 16'h0000;
    case (cmd_addr)
      `TSA_ADDR_STATUS: rd_word = {1'b0, flags[2], flags[1], flags[0],
                                   12'h000};
      `TSA_ADDR_CFG: rd_word = {cfg_q, 8'h00};
      `TSA_ADDR_TEMP: rd_word = {temp_value[15:3],
                                 res16 ? temp_value[2:0] : flags};
      `TSA_ADDR_ID: rd_word = {ID_CODE, 8'h00};
      `TSA_ADDR_CRIT: rd_word = crit_q;
      `TSA_ADDR_HYST: rd_word = {hyst_q, 8'h00};
      `TSA_ADDR_HIGH: rd_word = high_q;
      `TSA_ADDR_LOW: rd_word = low_q;
      default: rd_word = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  localparam [1:0] ST_CMD = 2'h0;
  localparam [1:0] ST_WR = 2'h1;
  localparam [1:0] ST_RD = 2'h2;
  localparam [1:0] ST_IDLE = 2'h3;

  reg [1:0] state_q;
  reg [4:0] cnt_q;
  reg wide_q;
  reg [15:0] out_sr_q;
  reg first_q;
  reg dout_q;
  reg dout_oe_q;
  reg rd_stb_q;
  reg [4:0] ones_q;
  wire [4:0] data_last = wide_q ? `TSA_WIDE_LAST : `TSA_NARROW_LAST;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= ST_CMD;
      cnt_q <= 5'h00;
      wide_q <= 1'b0;
      addr_q <= 3'h0;
      in_sr_q <= 16'h0000;
      out_sr_q <= 16'h0000;
      first_q <= 1'b0;
      dout_q <= 1'b0;
      dout_oe_q <= 1'b0;
      rd_stb_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_data_q <= 16'h0000;
      ones_q <= 5'h00;
      sif_rst_q <= 1'b0;
    end else begin
      rd_stb_q <= 1'b0;
      wr_stb_q <= 1'b0;
      sif_rst_q <= 1'b0;
      dout_oe_q <= cs_low;
      if (cs_rise) begin
        // partial frame is dropped, no write strobe
        state_q <= ST_IDLE;
        cnt_q <= 5'h00;
        ones_q <= 5'h00;
      end else if (cs_fall) begin
        // sclk edges outside a frame are ignored, frame starts here
        state_q <= ST_CMD;
        cnt_q <= 5'h00;
        ones_q <= 5'h00;
        dout_q <= 1'b0;
      end else if (cs_low && sclk_rise) begin
        in_sr_q <= {in_sr_q[14:0], din_f};
        cnt_q <= cnt_q + 5'h01;
        if (din_f && ones_q == `TSA_ONES_LAST) begin
          ones_q <= 5'h00;
          sif_rst_q <= 1'b1;
          state_q <= ST_CMD;
          cnt_q <= 5'h00;
        end else begin
          ones_q <= din_f ? ones_q + 5'h01 : 5'h00;
          case (state_q)
            ST_CMD: begin
              if (cnt_q == `TSA_CMD_LAST) begin
                cnt_q <= 5'h00;
                addr_q <= cmd_addr;
                wide_q <= cmd_wide;
                if (cmd_rd) begin
                  state_q <= ST_RD;
                  rd_stb_q <= 1'b1;
                  // msb shows before the first falling edge
                  dout_q <= rd_word[15];
                  out_sr_q <= {rd_word[14:0], 1'b0};
                  first_q <= 1'b1;
                end else begin
                  state_q <= ST_WR;
                end
              end
            end
            ST_WR: begin
              if (cnt_q == data_last) begin
                cnt_q <= 5'h00;
                state_q <= ST_CMD;
                wr_stb_q <= 1'b1;
                wr_data_q <= {in_sr_q[14:0], din_f};
              end
            end
            ST_RD: begin
              if (cnt_q == data_last) begin
                cnt_q <= 5'h00;
                state_q <= ST_CMD;
              end
            end
            default: begin
              cnt_q <= 5'h00;
            end
          endcase
        end
      end else if (cs_low && sclk_fall && state_q == ST_RD) begin
        // first fall keeps the msb, later falls shift
        first_q <= 1'b0;
        if (!first_q) begin
          dout_q <= out_sr_q[15];
          out_sr_q <= {out_sr_q[14:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // recovery window after a port reset
  // ----------------------------------------------------------------
  reg [16:0] rec_cnt_q;
  reg rec_q;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rec_cnt_q <= 17'h00000;
      rec_q <= 1'b0;
    end else if (sif_rst_q) begin
      rec_cnt_q <= RESYNC_CYCLES;
      rec_q <= 1'b1;
    end else if (rec_cnt_q != 17'h00000) begin
      rec_cnt_q <= rec_cnt_q - 17'h00001;
      rec_q <= (rec_cnt_q != 17'h00001);
    end else begin
      rec_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  reg sd_q;
  reg res16_q;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sd_q <= 1'b0;
      res16_q <= 1'b0;
    end else begin
      sd_q <= sd_mode;
      res16_q <= res16;
    end
  end

  // ----------------------------------------------------------------
  // alarm logic
  // ----------------------------------------------------------------
  wire int_oe;
  wire ct_oe;

  tsa_alarm u_alarm (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(sif_rst_q),
    .temp_value(temp_value),
    .high_limit(high_q),
    .low_limit(low_q),
    .critical_limit(crit_q),
    .hysteresis_value(hyst_q[3:0]),
    .cmp_mode(cfg_q[`TSA_CFG_CMP_BIT]),
    .shutdown(sd_mode),
    .int_pol_high(cfg_q[`TSA_CFG_INTPOL_BIT]),
    .ct_pol_high(cfg_q[`TSA_CFG_CTPOL_BIT]),
    .rd_stb(rd_stb_q),
    .int_oe_q(int_oe),
    .ct_oe_q(ct_oe),
    .flag_q(flags)
  );

  assign spi_dout = dout_q;
  assign spi_dout_oe = dout_oe_q;
  assign limit_alarm_oe = int_oe;
  assign critical_alarm_out_oe = ct_oe;
  assign shutdown = sd_q;
  assign resolution_16 = res16_q;
  assign sif_recovering = rec_q;

endmodule

// ### tsa_sensor_assertions.sv
module tsa_sensor_checker #(
  parameter [16:0] RESYNC_CYCLES = 17'd100
) (
  // system
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_din,
  input wire logic spi_dout,
  input wire logic spi_dout_oe,
  // converter side
  input wire logic [15:0] temp_value,
  input wire logic limit_alarm_oe,
  input wire logic critical_alarm_out_oe,
  input wire logic shutdown,
  input wire logic resolution_16,
  input wire logic sif_recovering
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [16:0] rec_cnt_q;
  always @(posedge clk_sys) begin
    if (!rst_n) rec_cnt_q <= 17'h00000;
    else if (sif_recovering) rec_cnt_q <= rec_cnt_q + 17'h00001;
    else rec_cnt_q <= 17'h00000;
  end
  a_dout_oe_idle: assert property (spi_cs_n [*8] |-> !spi_dout_oe)
    else $error("data out driven with chip select high");
  a_dout_sclk_high: assert property (
    (spi_sclk && !spi_cs_n) [*8] |=> $stable(spi_dout))
    else $error("data out moved while sclk high");
  a_dout_cs_idle: assert property (
    spi_cs_n [*8] |=> $stable(spi_dout))
    else $error("data out moved outside a frame");
  a_cfg_idle: assert property (spi_cs_n [*8] |=>
    $stable(shutdown) && $stable(resolution_16))
    else $error("configuration changed outside a frame");
  a_alarm_quiet: assert property (
    (spi_cs_n && $stable(temp_value)) [*8] |=>
    $stable(limit_alarm_oe) && $stable(critical_alarm_out_oe))
    else $error("alarm moved with no cause");
  a_recover_cause: assert property ($rose(sif_recovering) |->
    $past(spi_din, 3) && !$past(spi_cs_n, 3))
    else $error("port reset without ones on data in");
  a_recover_len: assert property ($fell(sif_recovering) |->
    rec_cnt_q == RESYNC_CYCLES) else $error("recovery length wrong");
  a_recover_dflt: assert property ($rose(sif_recovering) |->
    ##2 (!shutdown && !resolution_16) [*4])
    else $error("configuration not restored by port reset");
  c_recover: cover property ($rose(sif_recovering));
  c_limit: cover property ($rose(limit_alarm_oe));
  c_crit: cover property ($rose(critical_alarm_out_oe));
endmodule
bind tsa_sensor tsa_sensor_checker #(.RESYNC_CYCLES(RESYNC_CYCLES)) i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .spi_sclk(spi_sclk),
  .spi_cs_n(spi_cs_n), .spi_din(spi_din), .spi_dout(spi_dout),
  .spi_dout_oe(spi_dout_oe), .temp_value(temp_value),
  .limit_alarm_oe(limit_alarm_oe),
  .critical_alarm_out_oe(critical_alarm_out_oe), .shutdown(shutdown),
  .resolution_16(resolution_16), .sif_recovering(sif_recovering));

// ### tsa_spi_master.sv
module tsa_spi_master (
  // system
  input wire logic clk_sys,
  // serial pins
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_din,
  input wire logic spi_dout
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 16;
  initial begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_din = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one frame of n bits, msb first; rx keeps the last 16 samples
  task automatic xfer(input logic [31:0] tx, input int n,
                      output logic [15:0] rx);
    rx = 16'h0000;
    spi_cs_n <= 1'b0;
    tick(HALF);
    for (int i = n - 1; i >= 0; i--) begin
      spi_sclk <= 1'b0;
      spi_din <= tx[i];
      tick(HALF);
      spi_sclk <= 1'b1;
      rx = {rx[14:0], spi_dout};
      tick(HALF);
    end
    spi_cs_n <= 1'b1;
    // released data line shows the inverse of the last bit
    spi_din <= ~tx[0];
    tick(2 * HALF);
  endtask
  // clock runs with chip select high; the port must ignore it
  task automatic free_clk(input int n);
    spi_din <= 1'b1;
    repeat (n) begin
      spi_sclk <= 1'b0;
      tick(HALF);
      spi_sclk <= 1'b1;
      tick(HALF);
    end
  endtask
endmodule

// ### testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [16:0] RESYNC = 17'd200;
  // arbitrary identity value
  localparam [7:0] ID = 8'hA7;
  logic clk_sys, rst_n;
  logic [15:0] temp_value, r;
  wire sclk, cs_n, din, dout, dout_oe, lim_oe, crit_oe, sd, res16, rec;
  int miscompares, total_checks, cycles;
  tsa_sensor #(.ID_CODE(ID), .RESYNC_CYCLES(RESYNC)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_din(din), .spi_dout(dout), .spi_dout_oe(dout_oe),
    .temp_value(temp_value), .limit_alarm_oe(lim_oe),
    .critical_alarm_out_oe(crit_oe), .shutdown(sd),
    .resolution_16(res16), .sif_recovering(rec));
  tsa_spi_master i_master (.clk_sys(clk_sys), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_din(din), .spi_dout(dout));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one register access; widths 16 for 2,4,6,7 and 8 elsewhere
  task automatic xs(input logic rw, input logic [2:0] a,
                    input logic [15:0] d, output logic [15:0] v);
    logic [7:0] c;
    c = {1'b0, rw, a, 3'b000};
    if (a == 3'h2 || (a[2] && a != 3'h5)) begin
      i_master.xfer({8'h00, c, d}, 24, v);
    end else begin
      i_master.xfer({16'h0000, c, d[7:0]}, 16, v);
      v = {8'h00, v[7:0]};
    end
  endtask
  task automatic rdc(input logic [2:0] a, input logic [15:0] exp);
    logic [15:0] v;
    xs(1'b1, a, 16'h0000, v);
    check(v, exp);
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    logic [15:0] v;
    xs(1'b0, a, d, v);
  endtask
  task automatic set_temp(input logic [15:0] t);
    temp_value <= t;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic pins(input logic l, input logic c);
    check({14'h0000, lim_oe, crit_oe}, {14'h0000, l, c});
  endtask
  task automatic port_reset();
    i_master.xfer(32'hFFFFFFFF, 32, r);
    check({15'h0000, rec}, 16'h0001);
    check({15'h0000, sd}, 16'h0000);
    for (int k = 0; k < 400 && rec !== 1'b0; k++) @(posedge clk_sys);
    check({15'h0000, rec}, 16'h0000);
    rdc(3'h3, {8'h00, ID});
    rdc(3'h3, {8'h00, ID});
    rdc(3'h1, 16'h0000);
    rdc(3'h4, 16'h4980);
    rdc(3'h5, 16'h0005);
    rdc(3'h6, 16'h2000);
    rdc(3'h7, 16'h0500);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    temp_value = 16'h0C80;
    miscompares = 0;
    total_checks = 0;
    cycles = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    pins(1'b0, 1'b0);
    port_reset();
    $display("test defaults done");
    wr(3'h5, 16'h000A);
    check({15'h0000, dout_oe}, 16'h0000);
    rdc(3'h5, 16'h000A);
    wr(3'h6, 16'h1234);
    rdc(3'h6, 16'h1234);
    wr(3'h3, 16'h00FF);
    rdc(3'h3, {8'h00, ID});
    i_master.xfer({20'h00000, 8'h28, 4'hC}, 12, r);
    rdc(3'h5, 16'h000A);
    i_master.xfer({8'h28, 8'h0B, 8'h68, 8'h00}, 32, r);
    check(r & 16'h00FF, 16'h000B);
    i_master.free_clk(40);
    check({15'h0000, rec}, 16'h0000);
    rdc(3'h5, 16'h000B);
    $display("test access done");
    rdc(3'h2, 16'h0C80);
    set_temp(16'h2100);
    pins(1'b1, 1'b0);
    rdc(3'h2, 16'h2102);
    pins(1'b0, 1'b0);
    rdc(3'h1, 16'h0000);
    pins(1'b0, 1'b0);
    set_temp(16'h0C80);
    set_temp(16'h0400);
    pins(1'b1, 1'b0);
    wr(3'h1, 16'h0060);
    pins(1'b0, 1'b0);
    check({15'h0000, sd}, 16'h0001);
    port_reset();
    $display("test interrupt done");
    set_temp(16'h0C80);
    wr(3'h1, 16'h0010);
    set_temp(16'h2100);
    pins(1'b1, 1'b0);
    rdc(3'h0, 16'h0020);
    pins(1'b1, 1'b0);
    set_temp(16'h1F00);
    pins(1'b1, 1'b0);
    wr(3'h1, 16'h0070);
    pins(1'b1, 1'b0);
    wr(3'h1, 16'h0010);
    set_temp(16'h0C80);
    pins(1'b0, 1'b0);
    $display("test comparator done");
    set_temp(16'h4A00);
    pins(1'b1, 1'b1);
    set_temp(16'h4800);
    pins(1'b1, 1'b1);
    set_temp(16'h4600);
    pins(1'b1, 1'b0);
    wr(3'h1, 16'h0014);
    pins(1'b1, 1'b1);
    $display("test critical done");
    set_temp(16'h0C85);
    rdc(3'h2, 16'h0C80);
    wr(3'h1, 16'h0080);
    check({15'h0000, res16}, 16'h0001);
    rdc(3'h2, 16'h0C85);
    $display("test resolution done");
    stop_test();
  end
endmodule
